// ===== rtl/charge_timer_pkg.sv
// Shared constants and carriers for the charge sequencing and safety timer.
// Assumes a 10 MHz system clock and an oscillator tick of one clock cycle.
package charge_timer_pkg;

  // Safety timer geometry
  localparam int             TIMER_W       = 22;
  localparam logic [21:0]    TIMER_FULL    = 22'h3fffff;  // Last count before the limit
  localparam logic [21:0]    TRICKLE_LAST  = 22'h07ffff;  // One eighth of the full count
  localparam logic [3:0]     QUAL_LAST     = 4'he;        // Fifteenth good tick
  localparam logic [3:0]     QUAL_RESET    = 4'h0;
  localparam logic [21:0]    TIMER_RESET   = 22'h000000;

  // Register port map
  localparam int             ADDR_W        = 4;
  localparam logic [3:0]     REG_STATE     = 4'h0;
  localparam logic [3:0]     REG_TIMER     = 4'h4;
  localparam logic [3:0]     REG_CTRL      = 4'h8;
  localparam int             CTRL_RESTART  = 0;

  // Charge current and end-of-charge threshold settings, in mA
  localparam logic [15:0]    CURRENT_HIGH_MA = 16'h01f4;  // 500 mA
  localparam logic [15:0]    CURRENT_LOW_MA  = 16'h0064;  // 100 mA
  localparam logic [15:0]    THRESH_FIXED_MA = 16'h0005;  // 5 mA
  localparam logic [15:0]    THRESH_DIVISOR  = 16'h000a;  // One tenth
  localparam logic [7:0]     FOLDBACK_TEMP_C = 8'h64;     // 100 degrees
  localparam logic [15:0]    FOLDBACK_STEP   = 16'h0064;  // 100 mA per degree

  typedef enum logic [1:0] {
    PROG_RESISTOR,
    PROG_HIGH,
    PROG_LOW
  } current_prog_e;

  typedef enum logic [1:0] {
    THR_RESISTOR,
    THR_TENTH,
    THR_FIXED
  } thresh_mode_e;

  typedef enum {
    ST_IDLE,
    ST_TRICKLE,
    ST_FAST,
    ST_DONE,
    ST_HALT,
    ST_TIMEOUT
  } charge_state_e;

  // Comparator results from the analog side
  typedef struct packed {
    logic vbat_above_min;
    logic vbat_above_recharge;
    logic current_below_eoc;
    logic batt_temp_fault;
    logic batt_removed;
  } sense_s;

  // Current and threshold settings handed to the analog loops
  typedef struct packed {
    logic [15:0] current_ma;
    logic        current_from_resistor;
    thresh_mode_e thresh_mode;
    logic [15:0] thresh_ma;
    logic [15:0] foldback_ma;
  } loop_cfg_s;

endpackage : charge_timer_pkg

// ===== rtl/charge_cycle_safety_timer.sv
// Charge sequencing, safety timer, indicators and setting decode.
// Assumes all inputs synchronous to clk and osc_tick one cycle per oscillator period.
//
// Summary of operation
// - After completion, wait for recharge level, then start a new cycle.
// - Recharge start clears the safety timer to zero.
// - 22-bit timer advances per tick; full count limits fast charge.
// - Fast limit reached without end-of-charge latches a timeout fault.
// - Timeout latch clears only by power cycle or enable toggle.
// - Trickle limited to one eighth of fast limit, else timeout fault.
// - Trickle lasts at least 15 ticks before fast charge.
// - Time-limit pin low suppresses fast limit and its timeout fault.
// - With limit suppressed, status still reports end-of-charge.
// - Trickle limit always active; every cycle starts in trickle.
// - Current program selects 500mA high, 100mA low, else resistor.
// - Threshold tied to bias is one tenth, or 5mA if program low.
// - After end-of-charge, charging continues until fast limit expires.
// - Thermal reduction gives no end-of-charge unless above recharge level.
// - Battery below minimum clears qualification count, stays in trickle.
// - Status low at cycle start, latched high at end-of-charge.
// - Fault low on temperature fault, timeout or battery removal.
// - Cycle starts on reset, insertion, recharge, temperature recovery, enable.
`timescale 1ns/100ps

module charge_cycle_safety_timer
  import charge_timer_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          osc_tick,
  input  wire logic          enable_pin,
  input  wire logic          time_limit_enable_pin,
  input  current_prog_e      charge_current_program_pin,
  input  wire logic          end_charge_threshold_pin,
  input  wire logic [15:0]   resistor_current_ma,
  input  wire logic [7:0]    die_temp_c,
  input  sense_s             sense,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_write,
  input  wire logic          reg_read,
  output logic      [31:0]   reg_rdata,
  output logic               charge_on,
  output logic               fast_mode,
  output logic               status_out,
  output logic               status_oe,
  output logic               fault_out,
  output logic               fault_oe,
  output loop_cfg_s          loop_cfg
);

  charge_state_e state_q, state_d;
  logic [21:0]   timer_q, timer_d;
  logic [3:0]    qual_q, qual_d;
  logic          eoc_seen_q, eoc_seen_d;
  logic          status_hi_q, status_hi_d;
  logic          fault_lo_q, fault_lo_d;
  logic          eoc_qual;
  logic          start;
  logic          sw_restart;
  loop_cfg_s     cfg_d, cfg_q;
  logic [31:0]   rdata_d, rdata_q;

  // Register field helper
  function automatic logic [31:0] state_word(input charge_state_e st, input logic eoc,
                                             input logic st_hi, input logic flt_lo);
    logic [2:0] code;
    code = 3'(st);
    return {25'h0000000, flt_lo, st_hi, eoc, 1'b0, code};
  endfunction : state_word

  // Software restart request
  assign sw_restart = reg_write && (reg_addr == REG_CTRL) && reg_wdata[CTRL_RESTART];

  assign eoc_qual = sense.current_below_eoc && sense.vbat_above_recharge;

  // Charge sequencing next state
  always_comb begin
    state_d    = state_q;
    timer_d    = timer_q;
    qual_d     = qual_q;
    eoc_seen_d = eoc_seen_q;
    start      = 1'b0;
    if (!enable_pin) begin
      state_d = ST_IDLE;
    end else if (state_q == ST_TIMEOUT) begin
      state_d = ST_TIMEOUT;
    end else if (sense.batt_temp_fault || sense.batt_removed) begin
      state_d = ST_HALT;
    end else begin
      case (state_q)
        ST_IDLE: begin
          start = 1'b1;
        end
        ST_HALT: begin
          start = 1'b1;
        end
        ST_TRICKLE: begin
          if (osc_tick) begin
            timer_d = timer_q + 22'h000001;
            if (!sense.vbat_above_min) begin
              qual_d = QUAL_RESET;
            end else if (qual_q == QUAL_LAST) begin
              state_d = ST_FAST;
              timer_d = TIMER_RESET;
              qual_d  = QUAL_RESET;
            end else begin
              qual_d = qual_q + 4'h1;
            end
            if (state_d == ST_TRICKLE && timer_q == TRICKLE_LAST) begin
              state_d = ST_TIMEOUT;
            end
          end
          if (sw_restart) begin
            start = 1'b1;
          end
        end
        ST_FAST: begin
          if (eoc_qual) begin
            eoc_seen_d = 1'b1;
          end
          if (osc_tick) begin
            timer_d = timer_q + 22'h000001;
            if (timer_q == TIMER_FULL && time_limit_enable_pin) begin
              state_d = (eoc_seen_q || eoc_qual) ? ST_DONE : ST_TIMEOUT;
            end
          end
          if (sw_restart) begin
            start = 1'b1;
          end
        end
        ST_DONE: begin
          if (!sense.vbat_above_recharge || sw_restart) begin
            start = 1'b1;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
    if (start) begin
      state_d    = ST_TRICKLE;
      timer_d    = TIMER_RESET;
      qual_d     = QUAL_RESET;
      eoc_seen_d = 1'b0;
    end
  end

  // Charge sequencing registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q    <= ST_IDLE;
      timer_q    <= TIMER_RESET;
      qual_q     <= QUAL_RESET;
      eoc_seen_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      timer_q    <= timer_d;
      qual_q     <= qual_d;
      eoc_seen_q <= eoc_seen_d;
    end
  end

  // Indicator next values
  always_comb begin
    status_hi_d = !(state_d == ST_TRICKLE || state_d == ST_FAST) || eoc_seen_d;
    fault_lo_d  = enable_pin && (sense.batt_temp_fault || sense.batt_removed ||
                                 state_d == ST_TIMEOUT);
  end

  // Indicator registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_hi_q <= 1'b1;
      fault_lo_q  <= 1'b0;
    end else begin
      status_hi_q <= status_hi_d;
      fault_lo_q  <= fault_lo_d;
    end
  end

  // Open-drain pins, pulled high outside
  assign status_out = 1'b0;
  assign status_oe  = !status_hi_q;
  assign fault_out  = 1'b0;
  assign fault_oe   = fault_lo_q;
  assign charge_on  = (state_q == ST_TRICKLE) || (state_q == ST_FAST);
  assign fast_mode  = (state_q == ST_FAST);

  // Setting decode next values
  always_comb begin
    cfg_d = '0;
    case (charge_current_program_pin)
      PROG_HIGH: cfg_d.current_ma = CURRENT_HIGH_MA;
      PROG_LOW:  cfg_d.current_ma = CURRENT_LOW_MA;
      default: begin
        cfg_d.current_ma            = resistor_current_ma;
        cfg_d.current_from_resistor = 1'b1;
      end
    endcase
    if (!end_charge_threshold_pin) begin
      cfg_d.thresh_mode = THR_RESISTOR;
      cfg_d.thresh_ma   = 16'h0000;
    end else if (charge_current_program_pin == PROG_LOW) begin
      cfg_d.thresh_mode = THR_FIXED;
      cfg_d.thresh_ma   = THRESH_FIXED_MA;
    end else begin
      cfg_d.thresh_mode = THR_TENTH;
      cfg_d.thresh_ma   = cfg_d.current_ma / THRESH_DIVISOR;
    end
    if (die_temp_c > FOLDBACK_TEMP_C) begin
      cfg_d.foldback_ma = 16'({8'h00, die_temp_c - FOLDBACK_TEMP_C} * FOLDBACK_STEP);
    end
  end

  // Setting decode register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign loop_cfg = cfg_q;

  // Register read data, valid the cycle after the strobe
  always_comb begin
    rdata_d = 32'h00000000;
    if (reg_read) begin
      case (reg_addr)
        REG_STATE: rdata_d = state_word(state_q, eoc_seen_q, status_hi_q, fault_lo_q);
        REG_TIMER: rdata_d = {10'h000, timer_q};
        default:   rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_tick_at_full;
    osc_tick && state_q == ST_FAST && timer_q == TIMER_FULL && enable_pin &&
      !sense.batt_temp_fault && !sense.batt_removed && !sw_restart;
  endsequence

  property p_rch_restart;
    state_q == ST_DONE && enable_pin && !sense.vbat_above_recharge &&
      !sense.batt_temp_fault && !sense.batt_removed |=> state_q == ST_TRICKLE;
  endproperty
  a_rch_restart: assert property (p_rch_restart) else $error("No recharge restart");

  property p_timer_clear;
    state_q == ST_DONE && state_d == ST_TRICKLE |=> timer_q == TIMER_RESET;
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("Timer not cleared");

  property p_timer_step;
    osc_tick && state_q == ST_FAST && state_d == ST_FAST && !start
      |=> timer_q == $past(timer_q) + 22'h000001;
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("Timer step wrong");
  // Fault pin is set by the same edge that enters the latched state
  property p_timeout;
    s_tick_at_full ##0 (time_limit_enable_pin && !eoc_seen_q && !eoc_qual)
      |=> state_q == ST_TIMEOUT && fault_oe;
  endproperty
  a_timeout: assert property (p_timeout) else $error("Missing timeout fault");
  property p_latch_hold;
    state_q == ST_TIMEOUT && enable_pin |=> state_q == ST_TIMEOUT;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("Timeout latch leaked");
  property p_trickle_limit;
    osc_tick && state_q == ST_TRICKLE && timer_q == TRICKLE_LAST && enable_pin &&
      !sense.vbat_above_min && !sense.batt_temp_fault && !sense.batt_removed && !sw_restart
      |=> state_q == ST_TIMEOUT;
  endproperty
  a_trickle_limit: assert property (p_trickle_limit) else $error("Trickle limit missed");

  property p_min_trickle;
    state_q == ST_TRICKLE ##1 state_q == ST_FAST |-> $past(qual_q, 1) == QUAL_LAST;
  endproperty
  a_min_trickle: assert property (p_min_trickle) else $error("Trickle too short");
  property p_no_limit;
    s_tick_at_full ##0 !time_limit_enable_pin |=> state_q == ST_FAST;
  endproperty
  a_no_limit: assert property (p_no_limit) else $error("Limit not suppressed");

  property p_status_latch;
    state_q == ST_FAST && eoc_qual && state_d == ST_FAST |=> !status_oe;
  endproperty
  a_status_latch: assert property (p_status_latch) else $error("Status not latched");

  property p_fault_pin;
    enable_pin && sense.batt_removed |=> fault_oe;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("Fault pin not low");

  property p_qual_clear;
    osc_tick && state_q == ST_TRICKLE && state_d == ST_TRICKLE && !sense.vbat_above_min
      && !start |=> qual_q == QUAL_RESET;
  endproperty
  a_qual_clear: assert property (p_qual_clear) else $error("Qualify not cleared");

endmodule : charge_cycle_safety_timer

// ===== testbench/battery_model.sv
// Behavioural battery and adapter as seen by the charger's comparators.
// Assumes the bench loads the cell voltage and load state; clk is the charger clock.
`timescale 1ns/100ps

module battery_model
  import charge_timer_pkg::*;
#(
  parameter logic [15:0] MIN_MV  = 16'h0af0,  // Precondition level, 2800 mV
  parameter logic [15:0] RECH_MV = 16'h0fa0   // Recharge level, 4000 mV
)(
  input  wire logic        clk,
  input  wire logic        charge_on,
  input  wire logic        fast_mode,
  input  wire logic [15:0] set_mv,
  input  wire logic        load,
  input  wire logic        taper,
  input  wire logic        hot,
  input  wire logic        removed,
  output sense_s           sense
);
  logic [15:0] mv_q;
  logic [15:0] mv_d;

  // Cell voltage moves only when the bench loads a new value
  always_comb begin
    mv_d = load ? set_mv : mv_q;
  end

  always_ff @(posedge clk) begin
    mv_q <= mv_d;
  end

  // Comparators; current tapers only while the loop is in fast mode
  always_comb begin
    sense.vbat_above_min      = mv_q >= MIN_MV;
    sense.vbat_above_recharge = mv_q >= RECH_MV;
    sense.current_below_eoc   = taper & fast_mode & charge_on;
    sense.batt_temp_fault     = hot;
    sense.batt_removed        = removed;
  end
endmodule : battery_model

// ===== testbench/charge_cycle_safety_timer_test.sv
// Self-checking bench for the charge sequencing and safety timer.
// Assumes ticks are one clock wide and the battery model drives the comparators.
`timescale 1ns/100ps

module charge_cycle_safety_timer_test;
  import charge_timer_pkg::*;
  logic          clk, sys_rst, osc_tick, enable_pin, time_limit_enable_pin;
  logic          end_charge_threshold_pin, reg_write, reg_read, load, taper;
  logic          charge_on, fast_mode, status_out, status_oe, fault_out, fault_oe;
  logic [1:0]    flt;
  logic [3:0]    reg_addr;
  logic [7:0]    die_temp_c;
  logic [15:0]   resistor_current_ma, set_mv;
  logic [31:0]   reg_wdata, reg_rdata, rdat;
  current_prog_e charge_current_program_pin;
  sense_s        sense;
  loop_cfg_s     loop_cfg;
  int            failures, check_count;

  // Clock at 10 MHz
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  charge_cycle_safety_timer i_charge_cycle_safety_timer (
    .clk(clk), .sys_rst(sys_rst), .osc_tick(osc_tick), .enable_pin(enable_pin),
    .time_limit_enable_pin(time_limit_enable_pin),
    .charge_current_program_pin(charge_current_program_pin),
    .end_charge_threshold_pin(end_charge_threshold_pin),
    .resistor_current_ma(resistor_current_ma), .die_temp_c(die_temp_c), .sense(sense),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .charge_on(charge_on), .fast_mode(fast_mode),
    .status_out(status_out), .status_oe(status_oe), .fault_out(fault_out),
    .fault_oe(fault_oe), .loop_cfg(loop_cfg));

  battery_model i_battery_model (
    .clk(clk), .charge_on(charge_on), .fast_mode(fast_mode), .set_mv(set_mv), .load(load),
    .taper(taper), .hot(flt[1]), .removed(flt[0]), .sense(sense));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      osc_tick <= 1'b1;
      @(posedge clk);
      osc_tick <= 1'b0;
    end
  endtask : tick

  task automatic batt(input logic [15:0] mv);
    @(posedge clk);
    set_mv <= mv;
    load   <= 1'b1;
    @(posedge clk);
    load   <= 1'b0;
  endtask : batt

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  // Fourteen good ticks, one dip, then fifteen good ticks
  task automatic test_qual();
    batt(16'h0bb8);
    tick(14);
    cyc(1);
    chk("fast_early", 0, fast_mode);
    batt(16'h07d0);
    tick(1);
    batt(16'h0bb8);
    tick(14);
    cyc(1);
    chk("fast_after_dip", 0, fast_mode);
    tick(1);
    cyc(1);
    chk("fast_on", 1, fast_mode);
    rd(REG_TIMER, rdat);
    chk("timer_zero", 0, rdat[21:0]);
    tick(3);
    rd(REG_TIMER, rdat);
    chk("timer_three", 3, rdat[21:0]);
  endtask : test_qual

  // End-of-charge gating with the limit suppressed
  task automatic test_eoc();
    taper <= 1'b1;
    tick(2);
    cyc(3);
    chk("status_low_below_rech", 1, status_oe);
    batt(16'h1004);
    tick(1);
    cyc(3);
    chk("status_high", 0, status_oe);
    chk("status_level", 0, status_out);
    chk("still_fast", 1, fast_mode);
    taper <= 1'b0;
    wr(REG_CTRL, 32'h00000001);
    cyc(3);
    chk("restart_trickle", 0, fast_mode);
    chk("restart_status", 1, status_oe);
    rd(REG_STATE, rdat);
    chk("state_code", 1, rdat[2:0]);
    rd(REG_TIMER, rdat);
    chk("timer_cleared", 0, rdat[21:0]);
    rd(4'hc, rdat);
    chk("unmapped", 0, rdat);
  endtask : test_eoc

  // Temperature fault and removal, then recovery
  task automatic test_faults();
    for (int i = 1; i <= 2; i++) begin
      flt <= i[1:0];
      cyc(3);
      chk("fault_pin", 1, fault_oe);
      chk("fault_level", 0, fault_out);
      chk("halted", 0, charge_on);
      flt <= 2'b00;
      cyc(3);
      chk("recovered", 1, charge_on);
      chk("recover_trickle", 0, fast_mode);
      chk("fault_clear", 0, fault_oe);
    end
    enable_pin <= 1'b0;
    cyc(3);
    chk("disabled", 0, charge_on);
    enable_pin <= 1'b1;
    cyc(3);
    chk("reenabled", 1, charge_on);
  endtask : test_faults

  // Current program, threshold and foldback decode
  task automatic test_settings();
    current_prog_e    p [3];
    logic      [15:0] c [3];
    p = '{PROG_HIGH, PROG_LOW, PROG_RESISTOR};
    c = '{CURRENT_HIGH_MA, CURRENT_LOW_MA, 16'h012c};
    for (int i = 0; i < 3; i++) begin
      charge_current_program_pin <= p[i];
      cyc(3);
      chk("current", c[i], loop_cfg.current_ma);
      chk("threshold", (i == 1) ? THRESH_FIXED_MA : c[i] / THRESH_DIVISOR,
          loop_cfg.thresh_ma);
      chk("thresh_mode", (i == 1) ? THR_FIXED : THR_TENTH, loop_cfg.thresh_mode);
      chk("from_resistor", i == 2, loop_cfg.current_from_resistor);
    end
    end_charge_threshold_pin <= 1'b0;
    cyc(3);
    chk("thresh_mode_res", THR_RESISTOR, loop_cfg.thresh_mode);
    chk("thresh_res", 0, loop_cfg.thresh_ma);
    end_charge_threshold_pin <= 1'b1;
    die_temp_c <= FOLDBACK_TEMP_C + 8'h02;
    cyc(3);
    chk("foldback", 16'h0002 * FOLDBACK_STEP, loop_cfg.foldback_ma);
    die_temp_c <= FOLDBACK_TEMP_C;
    cyc(3);
    chk("foldback_edge", 0, loop_cfg.foldback_ma);
  endtask : test_settings

  // Power cycle in mid-run restarts a fresh cycle
  task automatic test_reset();
    sys_rst <= 1'b1;
    cyc(2);
    chk("rst_mid_charge", 0, charge_on);
    chk("rst_mid_fault", 0, fault_oe);
    chk("rst_mid_cfg", 0, loop_cfg.current_ma);
    sys_rst <= 1'b0;
    cyc(1);
    chk("rst_mid_trickle", 1, charge_on);
    chk("rst_mid_status", 1, status_oe);
    rd(REG_TIMER, rdat);
    chk("rst_mid_timer", 0, rdat[21:0]);
  endtask : test_reset

  task automatic results();
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    osc_tick = 1'b0;
    enable_pin = 1'b1;
    // limit pin held low, never overdriven
    time_limit_enable_pin = 1'b0;
    end_charge_threshold_pin = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h00000000;
    load = 1'b1;
    taper = 1'b0;
    flt = 2'b00;
    set_mv = 16'h07d0;
    die_temp_c = 8'h19;
    resistor_current_ma = 16'h012c;
    charge_current_program_pin = PROG_HIGH;
    failures = 0;
    check_count = 0;
    cyc(4);
    chk("rst_charge", 0, charge_on);
    chk("rst_status", 0, status_oe);
    sys_rst <= 1'b0;
    load <= 1'b0;
    cyc(3);
    chk("start_trickle", 1, charge_on);
    chk("start_status", 1, status_oe);
    test_qual();
    test_eoc();
    test_faults();
    test_settings();
    test_reset();
    results();
  end
endmodule : charge_cycle_safety_timer_test
